/* testbench/tdp_host_model.sv */
// Debugger-side model that clocks packets across the wired two-line link.
// Assumes pull-ups on both lines; the model only ever pulls a line low.
module tdp_host_model (
  output logic      hostClkLow,
  output logic      hostDataLow,
  input  wire logic clkLine,
  input  wire logic dataLine
);
  timeunit 1ns;
  timeprecision 1ns;
  int stretchMax = 0;
  initial begin
    hostClkLow = 1'b0;
    hostDataLow = 1'b0;
  end
  task automatic waitRel();
    int n;
    n = 0;
    hostClkLow = 1'b0;
    #1;
    while (clkLine !== 1'b1 && n < 300) begin
      #100 n++;
    end
    if (n > stretchMax) stretchMax = n;
  endtask
  task automatic bitCyc(input logic b, output logic seen);
    #100 hostDataLow = ~b;
    #300 waitRel();
    #200 seen = dataLine;
    #200 hostClkLow = 1'b1;
  endtask
  task automatic sendByte(input logic [7:0] d, input logic bad,
                          output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCyc(d[i], s);
    bitCyc(^d ^ bad, s);
    bitCyc(1'b1, ack);
  endtask
  task automatic recvByte(input logic ackVal, output logic [7:0] d,
                          output logic par);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bitCyc(1'b1, s);
      d = {d[6:0], s};
    end
    bitCyc(1'b1, par);
    bitCyc(ackVal, s);
  endtask
  task automatic startCond();
    #400 hostDataLow = 1'b1;
    #400 hostClkLow = 1'b1;
  endtask
  task automatic stopCond();
    #100 hostDataLow = 1'b1;
    #300 waitRel();
    #400 hostDataLow = 1'b0;
  endtask
  // stop then resend the whole command.
  task automatic command(input logic [31:0] p, input int n, input int bad,
                         output logic [3:0] first, output logic [3:0] last);
    logic a;
    for (int t = 0; t < 2; t++) begin
      startCond();
      last = 4'h0;
      for (int k = 0; k < n && last == 4'h0; k++) begin
        sendByte(p[31-8*k -: 8], k == bad && t == 0, a);
        last[k] = a;
      end
      stopCond();
      if (t == 0) first = last;
      if (last == 4'h0) break;
    end
  endtask
  task automatic readCmd(input logic [15:0] adr, input logic ackVal,
                         output logic [7:0] d, output logic par,
                         output logic [2:0] acks);
    logic [23:0] p;
    logic        a;
    p = {tdp_pkg::CMD_READ, adr};
    startCond();
    for (int k = 0; k < 3; k++) begin
      sendByte(p[23-8*k -: 8], 1'b0, a);
      acks[k] = a;
    end
    recvByte(ackVal, d, par);
    stopCond();
  endtask
endmodule

/* testbench/tdp_port_test.sv */
// Self-checking bench of the debug packet port and its FIFO.
// Assumes the host model file; the line pull-ups are modelled here.
module tdp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              memBusy = 1'b0;
  logic [7:0]        memRdData = 8'h00;
  logic              memRdValid = 1'b0;
  logic              cpuBreak = 1'b0;
  logic [15:0]       cpuPc = 16'h0000;
  logic              cpuDone = 1'b0;
  logic              clkOe, dataOe, dataOut, reqValid, rdReady, cpuHalt;
  logic              hClkLow, hDataLow;
  tdp_pkg::tdp_req_t memReq, lastReq;
  tdp_pkg::tdp_evt_t linkEvt;
  wire               clkLine = ~(hClkLow | clkOe);
  wire               dataLine = ~(hDataLow | dataOe);
  logic              memOn = 1'b1;
  int                fails = 0, testsRun = 0, reqCnt = 0, errCnt = 0;
  int                startCnt = 0, stopCnt = 0, c0, s0, p0, e0, n;
  logic [3:0]        a1, a2;
  logic [2:0]        a3;
  logic [7:0]        d;
  logic              par;
  logic [31:0]       rowPkt [7] = '{32'h021234a5, 32'h0200ff00,
    32'h038000ff, 32'h04000000, 32'h06000000, 32'h07004000, 32'h05000000};
  int                rowLen [7] = '{4, 4, 4, 1, 1, 3, 1};
  int                rowKind [7] = '{2, 2, 2, 1, -1, -1, 0};

  tdp_port tdp_port_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .dbgClkIn(clkLine), .dbgClkOe(clkOe), .dbgDataIn(dataLine),
    .dbgDataOe(dataOe), .dbgDataOut(dataOut), .memReq(memReq),
    .memReqValid(reqValid), .memBusy(memBusy), .memRdData(memRdData),
    .memRdValid(memRdValid), .memRdReady(rdReady),
    .cpuBreakInstr(cpuBreak), .cpuPc(cpuPc), .cpuInstrDone(cpuDone),
    .cpuHalt(cpuHalt), .linkEvt(linkEvt));
  tdp_host_model tdp_host_model_inst (.hostClkLow(hClkLow),
    .hostDataLow(hDataLow), .clkLine(clkLine), .dataLine(dataLine));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Memory stand-in: a read returns the low address byte xor 5a.
  always @(posedge ref_clk) begin
    if (memOn && memRdValid && rdReady === 1'b1) memRdValid <= 1'b0;
    if (memOn && reqValid === 1'b1 && memReq.wr === 1'b0 &&
        memReq.prog === 1'b0) begin
      memRdData <= memReq.addr[7:0] ^ 8'h5a;
      memRdValid <= 1'b1;
    end
    if (reqValid === 1'b1) lastReq <= memReq;
    if (reqValid === 1'b1) reqCnt <= reqCnt + 1;
    if (linkEvt.ackErr === 1'b1) errCnt <= errCnt + 1;
    if (linkEvt.frmStart === 1'b1) startCnt <= startCnt + 1;
    if (linkEvt.frmStop === 1'b1) stopCnt <= stopCnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    wrapUp();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle();
    check("idle", {clkOe, dataOe, reqValid, cpuHalt}, 4'h0);
    check("dout", dataOut, 1'b0);
    for (int r = 0; r < 7; r++) begin
      c0 = reqCnt;
      s0 = startCnt;
      p0 = stopCnt;
      tdp_host_model_inst.command(rowPkt[r], rowLen[r], 9, a1, a2);
      settle();
      check("acks", a1, 4'h0);
      check("start", startCnt - s0, 1);
      check("stop", stopCnt - p0, 1);
      if (rowKind[r] == 2) begin
        check("req", reqCnt - c0, 1);
        check("adr", lastReq.addr, rowPkt[r][23:8]);
        check("dat", lastReq.data, rowPkt[r][7:0]);
        check("prg", lastReq.prog, rowPkt[r][31:24] == 8'h03);
      end else if (rowKind[r] >= 0) check("halt", cpuHalt, rowKind[r]);
    end
    // Bad parity on the data packet, then the whole command again.
    c0 = reqCnt;
    tdp_host_model_inst.command(32'h02abcd11, 4, 3, a1, a2);
    settle();
    check("badack", a1, 4'h8);
    check("retry", a2, 4'h0);
    check("once", reqCnt - c0, 1);
    check("rreq", lastReq[23:0], 24'habcd11);
    // Read with the host refusing the returned byte.
    e0 = errCnt;
    tdp_host_model_inst.readCmd(16'h0033, 1'b1, d, par, a3);
    settle();
    check("rdata", d, 8'h69);
    check("rpar", ^{d, par}, 1'b0);
    check("racks", a3, 3'h0);
    check("ackerr", errCnt - e0, 1);
    // Busy memory stretches the clock.
    c0 = reqCnt;
    fork
      tdp_host_model_inst.command(32'h02beef3c, 4, 9, a1, a2);
      begin
        wait (reqCnt == c0 + 1);
        memBusy <= 1'b1;
        repeat (60) @(posedge ref_clk);
        memBusy <= 1'b0;
      end
    join
    settle();
    check("stretch", tdp_host_model_inst.stretchMax > 5, 1'b1);
    check("sreq", lastReq[23:0], 24'hbeef3c);
    // Break instruction, address breakpoint, then a step command sent while the pc still sits on the breakpoint.
    for (int k = 0; k < 3; k++) begin
      tdp_host_model_inst.command({k == 2 ? 8'h06 : 8'h05, 24'h0}, 1, 9,
                                  a1, a2);
      settle();
      if (k < 2) check("run", cpuHalt, 1'b0);
      cpuPc <= k == 1 ? 16'h0040 : 16'h0100;
      cpuBreak <= k == 0;
      cpuDone <= k != 0;
      @(posedge ref_clk);
      cpuBreak <= 1'b0;
      cpuDone <= 1'b0;
      settle();
      check("brk", cpuHalt, 1'b1);
    end
    // Read buffer: still holds the refused byte; top it up to full, then
    // drain it through read commands.
    memOn <= 1'b0;
    memRdValid <= 1'b1;
    memRdData <= 8'h10;
    n = 0;
    while (n < 7) begin
      @(posedge ref_clk);
      if (rdReady === 1'b1) begin
        n++;
        memRdData <= 8'h10 + 8'(n);
      end
    end
    memRdValid <= 1'b0;
    settle();
    check("full", rdReady, 1'b0);
    for (int k = 0; k < 8; k++) begin
      tdp_host_model_inst.readCmd(16'h0000, 1'b0, d, par, a3);
      settle();
      check("fifo", d, k == 0 ? 8'h69 : 8'h10 + 8'(k - 1));
    end
    // With nothing buffered the device never drives the line in the read byte.
    tdp_host_model_inst.readCmd(16'h0000, 1'b0, d, par, a3);
    settle();
    check("empty", d, 8'hff);
    wrapUp();
  end
endmodule

/* verilog/tdp_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides.
// Assumes one clock domain shared by source and sink.
module tdp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  wire  doPush = inValid && inReady;
  wire  doPop  = outValid && outReady;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + AW'(1);
      if (doPop) rdPtr_r <= rdPtr_r + AW'(1);
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule

/* verilog/tdp_pkg.sv */
// Shared constants and types of the two-wire debug packet port.
// Assumes a single 10 MHz reference clock and no software registers.
package tdp_pkg;
  localparam int unsigned PKT_BITS    = 10;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam logic [3:0]  PARITY_IDX  = 4'h8;
  localparam logic [3:0]  ACK_IDX     = 4'h9;
  // Clock hold while an internal operation completes.
  localparam int unsigned HOLD_NS     = 2000;
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned HOLD_CYC    = HOLD_NS / CLK_NS;
  localparam logic [7:0]  HOLD_CNT    = 8'(HOLD_CYC);
  // Command codes of the first packet of a frame.
  localparam logic [7:0]  CMD_READ    = 8'h01;
  localparam logic [7:0]  CMD_WRITE   = 8'h02;
  localparam logic [7:0]  CMD_PROG    = 8'h03;
  localparam logic [7:0]  CMD_HALT    = 8'h04;
  localparam logic [7:0]  CMD_RUN     = 8'h05;
  localparam logic [7:0]  CMD_STEP    = 8'h06;
  localparam logic [7:0]  CMD_BRKPT   = 8'h07;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_SEND = 5'h04,
    ST_ACKW = 5'h08,
    ST_ERR  = 5'h10
  } tdp_state_t;

  typedef struct packed {
    logic        wr;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  data;
  } tdp_req_t;

  typedef struct packed {
    logic frmStart;
    logic frmStop;
    logic ackErr;
  } tdp_evt_t;
endpackage

/* verilog/tdp_port.sv */
// Device end of the two-wire debug packet port.
// Assumes the host drives the debug clock and both lines are pulled up.
//
// Summary of operation
// - each transfer is ten bits: eight data, parity, acknowledge.
// - transmitter sets parity so ones over data and parity are even.
// - receiver drives acknowledge low on good parity, else releases.
// - transmitter seeing acknowledge high on tenth clock flags an error.
// - a command is packets framed by start and stop conditions.
// - debug clock pin is sampled by the device, which also pulls it low to stretch the clock.
// - data pin drives while reading out, listens while programming.
// - both lines are driven only open-drain, forming a wired-AND.
// - host reaches peripherals, RAM, flash and EEPROM.
// - halt on break instruction, single step and one address breakpoint.
// - host may program flash, EEPROM, fuse and lock bits.
module tdp_port (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 dbgClkIn,
  output logic                      dbgClkOe,
  input  wire logic                 dbgDataIn,
  output logic                      dbgDataOe,
  output logic                      dbgDataOut,
  output tdp_pkg::tdp_req_t         memReq,
  output logic                      memReqValid,
  input  wire logic                 memBusy,
  input  wire logic [7:0]           memRdData,
  input  wire logic                 memRdValid,
  output logic                      memRdReady,
  input  wire logic                 cpuBreakInstr,
  input  wire logic [15:0]          cpuPc,
  input  wire logic                 cpuInstrDone,
  output logic                      cpuHalt,
  output tdp_pkg::tdp_evt_t         linkEvt
);
  import_free: begin end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] clkSync_r;
  logic [1:0] datSync_r;
  logic       clkPrev_r;
  logic       datPrev_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkSync_r <= 2'h3;
      datSync_r <= 2'h3;
      clkPrev_r <= 1'h1;
      datPrev_r <= 1'h1;
    end else begin
      clkSync_r <= {clkSync_r[0], dbgClkIn};
      datSync_r <= {datSync_r[0], dbgDataIn};
      clkPrev_r <= clkSync_r[1];
      datPrev_r <= datSync_r[1];
    end
  end

  wire sClk    = clkSync_r[1];
  wire sDat    = datSync_r[1];
  wire clkRise = sClk && !clkPrev_r;
  wire clkFall = !sClk && clkPrev_r;
  wire startCond = sClk && clkPrev_r && datPrev_r && !sDat;
  wire stopCond  = sClk && clkPrev_r && !datPrev_r && sDat;

  ////////////////////////////////////////////////////////////////////
  // Packet engine.
  tdp_pkg::tdp_state_t state_r;
  tdp_pkg::tdp_state_t state_nxt;
  logic [3:0]  bitIdx_r;
  logic [7:0]  shReg_r;
  logic        parity_r;
  logic        inFrame_r;
  logic [1:0]  byteNo_r;
  logic [7:0]  cmd_r;
  logic [15:0] addr_r;
  logic        dataOe_r;
  logic        clkOe_r;
  logic [7:0]  holdCnt_r;
  logic [15:0] brkAddr_r;
  logic        brkEn_r;
  logic        stepArm_r;
  logic        halt_r;
  logic        reqValid_r;
  tdp_pkg::tdp_req_t req_r;
  tdp_pkg::tdp_evt_t evt_r;

  function automatic logic evenPar(input logic [7:0] d);
    evenPar = ^d;
  endfunction

  wire lastData   = (bitIdx_r == 4'(tdp_pkg::DATA_BITS - 1));
  wire atParity   = (bitIdx_r == tdp_pkg::PARITY_IDX);
  wire atAck      = (bitIdx_r == tdp_pkg::ACK_IDX);
  wire rxGood     = (evenPar(shReg_r) == sDat);
  wire isRead     = (cmd_r == tdp_pkg::CMD_READ);
  wire fifoOk;
  wire [7:0] fifoData;
  // The first read bit is driven on the same fall that enters the send state.
  wire goSend = (state_r == tdp_pkg::ST_RECV) && isRead &&
                (byteNo_r == 2'h3) && fifoOk && (bitIdx_r == 4'h0) && clkFall;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tdp_pkg::ST_IDLE: if (startCond) state_nxt = tdp_pkg::ST_RECV;
      tdp_pkg::ST_RECV: if (stopCond) state_nxt = tdp_pkg::ST_IDLE;
      tdp_pkg::ST_SEND: if (stopCond) state_nxt = tdp_pkg::ST_IDLE;
      tdp_pkg::ST_ACKW: if (stopCond) state_nxt = tdp_pkg::ST_IDLE;
      tdp_pkg::ST_ERR:  if (stopCond) state_nxt = tdp_pkg::ST_IDLE;
      default:          state_nxt = tdp_pkg::ST_IDLE;
    endcase
    if (startCond) state_nxt = tdp_pkg::ST_RECV;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= tdp_pkg::ST_IDLE;
      bitIdx_r   <= 4'h0;
      shReg_r    <= 8'h00;
      parity_r   <= 1'h0;
      inFrame_r  <= 1'h0;
      byteNo_r   <= 2'h0;
      cmd_r      <= 8'h00;
      addr_r     <= 16'h0000;
      dataOe_r   <= 1'h0;
      reqValid_r <= 1'h0;
      req_r      <= '0;
      evt_r      <= '0;
    end else begin
      evt_r      <= '0;
      reqValid_r <= 1'h0;
      if (startCond || stopCond) begin
        bitIdx_r  <= 4'h0;
        byteNo_r  <= 2'h0;
        dataOe_r  <= 1'h0;
        inFrame_r <= startCond;
        evt_r.frmStart <= startCond;
        evt_r.frmStop  <= stopCond;
      end else if (clkRise && inFrame_r) begin
        bitIdx_r <= atAck ? 4'h0 : bitIdx_r + 4'h1;
        if (state_r == tdp_pkg::ST_RECV && bitIdx_r < tdp_pkg::PARITY_IDX)
          shReg_r <= {shReg_r[6:0], sDat};
        if (state_r == tdp_pkg::ST_RECV && atParity) parity_r <= rxGood;
        if (state_r == tdp_pkg::ST_SEND && atAck && sDat) begin
          evt_r.ackErr <= 1'h1;
        end
        if (state_r == tdp_pkg::ST_RECV && atAck && parity_r) begin
          byteNo_r <= byteNo_r + 2'h1;
          case (byteNo_r)
            2'h0: cmd_r <= shReg_r;
            2'h1: addr_r[15:8] <= shReg_r;
            2'h2: addr_r[7:0] <= shReg_r;
            default: begin
              reqValid_r <= (cmd_r != tdp_pkg::CMD_BRKPT);
              req_r.wr   <= (cmd_r == tdp_pkg::CMD_WRITE);
              req_r.prog <= (cmd_r == tdp_pkg::CMD_PROG);
              req_r.addr <= addr_r;
              req_r.data <= shReg_r;
              addr_r     <= addr_r + 16'h0001;
            end
          endcase
        end
      end else if (clkFall && inFrame_r) begin
        if (state_r == tdp_pkg::ST_SEND || goSend) begin
          if (bitIdx_r < tdp_pkg::PARITY_IDX)
            dataOe_r <= !fifoData[3'(4'h7 - bitIdx_r)];
          else if (atParity)
            dataOe_r <= !evenPar(fifoData);
          else
            dataOe_r <= 1'h0;
        end else if (state_r == tdp_pkg::ST_RECV) begin
          dataOe_r <= atAck && parity_r;
        end else begin
          dataOe_r <= 1'h0;
        end
      end
      // One byte per read: after an accepted byte the line stays released
      // so that the host can make its stop condition.
      if (goSend)
        state_r <= tdp_pkg::ST_SEND;
      else if (state_r == tdp_pkg::ST_SEND && evt_r.ackErr)
        state_r <= tdp_pkg::ST_ERR;
      else if (state_r == tdp_pkg::ST_SEND && clkRise && atAck && !sDat &&
               !startCond && !stopCond)
        state_r <= tdp_pkg::ST_ACKW;
      else
        state_r <= state_nxt;
      if (isRead && byteNo_r == 2'h2 && clkRise && atAck && parity_r &&
          state_r == tdp_pkg::ST_RECV) begin
        reqValid_r <= 1'h1;
        req_r.wr   <= 1'h0;
        req_r.prog <= 1'h0;
        req_r.addr <= {addr_r[15:8], shReg_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data buffer, popped when a sent packet is acknowledged.
  wire popByte = (state_r == tdp_pkg::ST_SEND) && clkRise && atAck && !sDat;
  tdp_fifo #(.WIDTH(tdp_pkg::DATA_BITS), .DEPTH(tdp_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .inData   (memRdData),
    .inValid  (memRdValid),
    .inReady  (memRdReady),
    .outData  (fifoData),
    .outValid (fifoOk),
    .outReady (popByte)
  );

  ////////////////////////////////////////////////////////////////////
  // Clock stretch and halt control.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkOe_r   <= 1'h0;
      holdCnt_r <= 8'h00;
      brkAddr_r <= 16'h0000;
      brkEn_r   <= 1'h0;
      stepArm_r <= 1'h0;
      halt_r    <= 1'h0;
    end else begin
      if (reqValid_r) holdCnt_r <= tdp_pkg::HOLD_CNT;
      else if (holdCnt_r != 8'h00) holdCnt_r <= holdCnt_r - 8'h01;
      clkOe_r <= inFrame_r && !sClk && (memBusy || holdCnt_r != 8'h00);
      if (clkRise && atAck && parity_r && byteNo_r == 2'h2 &&
          cmd_r == tdp_pkg::CMD_BRKPT) begin
        brkAddr_r <= {addr_r[15:8], shReg_r};
        brkEn_r   <= 1'h1;
      end
      if (clkRise && atAck && parity_r && byteNo_r == 2'h0) begin
        if (shReg_r == tdp_pkg::CMD_STEP) stepArm_r <= 1'h1;
      end
      if (cpuBreakInstr || (brkEn_r && cpuPc == brkAddr_r) ||
          (stepArm_r && cpuInstrDone) ||
          (byteNo_r == 2'h1 && cmd_r == tdp_pkg::CMD_HALT)) begin
        halt_r    <= 1'h1;
        stepArm_r <= 1'h0;
      end else if (byteNo_r == 2'h1 && (cmd_r == tdp_pkg::CMD_RUN ||
                   cmd_r == tdp_pkg::CMD_STEP)) begin
        halt_r <= 1'h0;
      end
    end
  end

  assign dbgClkOe    = clkOe_r;
  assign dbgDataOe   = dataOe_r;
  assign dbgDataOut  = 1'h0;
  assign memReq      = req_r;
  assign memReqValid = reqValid_r;
  assign cpuHalt     = halt_r;
  assign linkEvt     = evt_r;

  ////////////////////////////////////////////////////////////////////
  // Checks.
  a_ack_after_good: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == tdp_pkg::ST_RECV && clkFall && atAck && parity_r
     && inFrame_r && !startCond && !stopCond) |=> dataOe_r)
    else $error("good packet not acknowledged");
  a_parity_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == tdp_pkg::ST_SEND && clkFall && atParity && inFrame_r
     && !startCond && !stopCond) |=> dataOe_r == !evenPar(fifoData))
    else $error("parity bit driven wrong");
  a_ack_err_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == tdp_pkg::ST_SEND && clkRise && atAck && sDat && inFrame_r
     && !startCond && !stopCond) |=> linkEvt.ackErr)
    else $error("acknowledge error missed");
  a_bit_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bitIdx_r <= tdp_pkg::ACK_IDX)
    else $error("bit counter past ten");
  a_frame_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
    startCond |=> inFrame_r && bitIdx_r == 4'h0 && !dataOe_r)
    else $error("start not framed");
  a_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !dbgDataOut)
    else $error("data pin driven high");
  a_clk_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(reqValid_r) |-> ##1 holdCnt_r == tdp_pkg::HOLD_CNT)
    else $error("hold count not loaded");
  a_break_halt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cpuBreakInstr |=> cpuHalt)
    else $error("break did not halt");
endmodule
